// ==== mtcsr_bank.sv ====
// Operation
// [RULE1] Without option, enable bits 31:16 are read-write, each gating fast line x.
// [RULE2] Without option, bits 11, 7, 3 gate external, timer, software lines.
// [RULE3] Without option, the remaining low enable bits read zero, writes ignored.
// [RULE4] With option, the whole enable register reads zero.
// [RULE5] Vector base bits 31:7 read-write, bits 6:2 zero, 128-byte alignment.
// [RULE6] Without option, mode keeps only legal values 0 direct, 1 vectored.
// [RULE7] Reset loads base from boot address, mode 01 or 11 with option.
// [RULE8] Traps branch to handler using base bits 31:7, direct or vectored.
// [RULE9] Non-maskable interrupt goes to table entry 15 in both modes.
// [RULE10] With option, mode is fixed at 3 and writes leave it.
// [RULE11] Table base exists only with option, bits 31:6, low bits zero.
// [RULE12] Table base aligned to max of 64 and 2^(2+id width) bytes.
// [RULE13] Status high, environment and event selector registers read zero.
// [RULE14] Counter-enable bits 0 and 2 allow user counter reads, else illegal.
// [RULE15] Inhibit bits 0 and 2 stop counters, reset set, others zero.
// [RULE16] Scratch word is plain 32-bit read-write storage, reset zero.
`include "mtcsr_consts.svh"

module mtcsr_bank
  import mtcsr_pkg::*;
#(
  parameter bit VECT_CTRL_EN = 1'b0,
  parameter int ID_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] boot_addr,
  input wire mtcsr_req_t csr_req,
  output mtcsr_rsp_t csr_rsp,
  input wire logic [31:0] irq_lines,
  output logic [31:0] irq_enabled,
  input wire mtcsr_trap_t trap_req,
  output logic handler_valid,
  output logic [31:0] handler_pc,
  output logic cycle_inhibit,
  output logic retired_inhibit
);

  localparam int TVT_LSB = (`MTCSR_TVT_ID_LSB + ID_WIDTH > `MTCSR_TVT_MIN_LSB) ?
    (`MTCSR_TVT_ID_LSB + ID_WIDTH) : `MTCSR_TVT_MIN_LSB;
  localparam logic [31:0] TVT_MASK = 32'hffffffff << TVT_LSB;

  // Elaboration check on the identifier width
  if (ID_WIDTH < 1 || ID_WIDTH > 29) begin : g_bad_id
    $error("mtcsr_bank: ID_WIDTH out of range");
  end

  function automatic logic in_events(input logic [11:0] a);
    in_events = (a >= `MTCSR_A_EVT_LO) && (a <= `MTCSR_A_EVT_HI);
  endfunction : in_events

  function automatic logic [1:0] legal_mode(input logic [1:0] w, input logic [1:0] cur);
    if (VECT_CTRL_EN) begin
      legal_mode = `MTCSR_MODE_CLIC; // RULE10
    end else if (w == `MTCSR_MODE_DIRECT || w == `MTCSR_MODE_VECT) begin
      legal_mode = w; // RULE6
    end else begin
      legal_mode = cur; // RULE6
    end
  endfunction : legal_mode

  mtcsr_state_t state_ff;
  mtcsr_state_t nxt_state;
  logic [31:0] ie_ff;
  logic [31:0] nxt_ie;
  logic [31:0] tvec_base_ff;
  logic [31:0] nxt_tvec_base;
  logic [1:0] tvec_mode_ff;
  logic [1:0] nxt_tvec_mode;
  logic [31:0] tvt_ff;
  logic [31:0] nxt_tvt;
  logic [31:0] cnten_ff;
  logic [31:0] nxt_cnten;
  logic [31:0] inhib_ff;
  logic [31:0] nxt_inhib;
  logic [31:0] scratch_ff;
  logic [31:0] nxt_scratch;
  mtcsr_rsp_t rsp_ff;
  mtcsr_rsp_t nxt_rsp;
  logic [31:0] irq_en_ff;
  logic [31:0] nxt_irq_en;
  logic hvalid_ff;
  logic nxt_hvalid;
  logic [31:0] hpc_ff;
  logic [31:0] nxt_hpc;

  logic wr;
  logic [31:0] rd_val;
  logic rd_hit;
  logic rd_illegal;

  assign wr = csr_req.access && csr_req.write && !csr_req.user_mode;

  // Read decode
  always_comb begin
    rd_val = `MTCSR_ZERO;
    rd_hit = 1'b1;
    rd_illegal = 1'b0;
    unique case (csr_req.addr)
      `MTCSR_A_IE: begin
        rd_val = VECT_CTRL_EN ? `MTCSR_ZERO : ie_ff; // RULE4
      end
      `MTCSR_A_TVEC: begin
        rd_val = tvec_base_ff | {30'h0, tvec_mode_ff}; // RULE5
      end
      `MTCSR_A_CNTEN: begin
        rd_val = cnten_ff;
      end
      `MTCSR_A_TVT: begin
        rd_hit = VECT_CTRL_EN; // RULE11
        rd_val = VECT_CTRL_EN ? tvt_ff : `MTCSR_ZERO;
      end
      `MTCSR_A_ENVLO, `MTCSR_A_STATH, `MTCSR_A_ENVHI: begin
        rd_val = `MTCSR_ZERO; // RULE13
      end
      `MTCSR_A_INHIB: begin
        rd_val = inhib_ff;
      end
      `MTCSR_A_SCR: begin
        rd_val = scratch_ff;
      end
      `MTCSR_A_UCYC, `MTCSR_A_UCYCH: begin
        rd_hit = 1'b0;
        rd_illegal = csr_req.user_mode && !cnten_ff[`MTCSR_CY_BIT]; // RULE14
      end
      `MTCSR_A_URET, `MTCSR_A_URETH: begin
        rd_hit = 1'b0;
        rd_illegal = csr_req.user_mode && !cnten_ff[`MTCSR_IR_BIT]; // RULE14
      end
      default: begin
        rd_hit = in_events(csr_req.addr); // RULE13
        rd_val = `MTCSR_ZERO;
      end
    endcase
  end

  // Register next values
  always_comb begin
    nxt_state = state_ff;
    nxt_ie = ie_ff;
    nxt_tvec_base = tvec_base_ff;
    nxt_tvec_mode = tvec_mode_ff;
    nxt_tvt = tvt_ff;
    nxt_cnten = cnten_ff;
    nxt_inhib = inhib_ff;
    nxt_scratch = scratch_ff;
    unique case (state_ff)
      MTCSR_BOOT_WAIT: begin
        nxt_tvec_base = boot_addr & `MTCSR_TVEC_BASE_MASK; // RULE7
        nxt_state = MTCSR_RUN;
      end
      MTCSR_RUN: begin
        if (wr) begin
          unique case (csr_req.addr)
            `MTCSR_A_IE: begin
              if (!VECT_CTRL_EN) begin
                nxt_ie = csr_req.wdata & `MTCSR_IE_MASK; // RULE1 RULE2 RULE3
              end
            end
            `MTCSR_A_TVEC: begin
              nxt_tvec_base = csr_req.wdata & `MTCSR_TVEC_BASE_MASK; // RULE5
              nxt_tvec_mode = legal_mode(csr_req.wdata[1:0], tvec_mode_ff);
            end
            `MTCSR_A_CNTEN: begin
              nxt_cnten = csr_req.wdata & `MTCSR_CNT_MASK; // RULE14
            end
            `MTCSR_A_TVT: begin
              if (VECT_CTRL_EN) begin
                nxt_tvt = csr_req.wdata & TVT_MASK; // RULE11 RULE12
              end
            end
            `MTCSR_A_INHIB: begin
              nxt_inhib = csr_req.wdata & `MTCSR_CNT_MASK; // RULE15
            end
            `MTCSR_A_SCR: begin
              nxt_scratch = csr_req.wdata; // RULE16
            end
            default: begin
              nxt_scratch = scratch_ff;
            end
          endcase
        end
      end
      default: begin
        nxt_state = MTCSR_RUN;
      end
    endcase
  end

  // Response, enable gating and handler address
  always_comb begin
    nxt_rsp.valid = csr_req.access;
    nxt_rsp.hit = csr_req.access && rd_hit;
    nxt_rsp.illegal = csr_req.access && rd_illegal;
    nxt_rsp.rdata = (csr_req.access && !rd_illegal) ? rd_val : `MTCSR_ZERO;
    nxt_irq_en = VECT_CTRL_EN ? `MTCSR_ZERO : (irq_lines & ie_ff); // RULE1 RULE2 RULE4
    nxt_hvalid = trap_req.take;
    nxt_hpc = hpc_ff;
    if (trap_req.take) begin
      if (trap_req.nmi) begin
        nxt_hpc = {tvec_base_ff[31:`MTCSR_BASE_LSB], `MTCSR_NMI_IDX, `MTCSR_ALIGN_PAD}; // RULE9
      end else if (trap_req.irq && tvec_mode_ff == `MTCSR_MODE_VECT) begin
        nxt_hpc = {tvec_base_ff[31:`MTCSR_BASE_LSB], trap_req.cause,
                   `MTCSR_ALIGN_PAD}; // RULE8
      end else begin
        nxt_hpc = tvec_base_ff; // RULE8
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= MTCSR_BOOT_WAIT;
      ie_ff <= `MTCSR_ZERO;
      tvec_base_ff <= `MTCSR_ZERO;
      tvec_mode_ff <= VECT_CTRL_EN ? `MTCSR_MODE_CLIC : `MTCSR_MODE_VECT; // RULE7
      tvt_ff <= `MTCSR_ZERO;
      cnten_ff <= `MTCSR_ZERO;
      inhib_ff <= `MTCSR_INHIB_RST; // RULE15
      scratch_ff <= `MTCSR_ZERO; // RULE16
      rsp_ff <= '0;
      irq_en_ff <= `MTCSR_ZERO;
      hvalid_ff <= 1'b0;
      hpc_ff <= `MTCSR_ZERO;
    end else begin
      state_ff <= nxt_state;
      ie_ff <= nxt_ie;
      tvec_base_ff <= nxt_tvec_base;
      tvec_mode_ff <= nxt_tvec_mode;
      tvt_ff <= nxt_tvt;
      cnten_ff <= nxt_cnten;
      inhib_ff <= nxt_inhib;
      scratch_ff <= nxt_scratch;
      rsp_ff <= nxt_rsp;
      irq_en_ff <= nxt_irq_en;
      hvalid_ff <= nxt_hvalid;
      hpc_ff <= nxt_hpc;
    end
  end

  assign csr_rsp = rsp_ff;
  assign irq_enabled = irq_en_ff;
  assign handler_valid = hvalid_ff;
  assign handler_pc = hpc_ff;
  assign cycle_inhibit = inhib_ff[`MTCSR_CY_BIT]; // RULE15
  assign retired_inhibit = inhib_ff[`MTCSR_IR_BIT]; // RULE15

endmodule : mtcsr_bank

// ==== mtcsr_bank_chk.sv ====
module mtcsr_bank_chk
  import mtcsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] boot_addr,
  input wire mtcsr_req_t csr_req,
  input wire mtcsr_rsp_t csr_rsp,
  input wire logic [31:0] irq_lines,
  input wire logic [31:0] irq_enabled,
  input wire mtcsr_trap_t trap_req,
  input wire logic handler_valid,
  input wire logic [31:0] handler_pc,
  input wire logic cycle_inhibit,
  input wire logic retired_inhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ie_gate_a: assert property (
    1'b1 |=> (irq_enabled & ~$past(irq_lines)) == 32'h00000000) else $error("line not requested");
  ie_mask_a: assert property (
    (irq_enabled & 32'h0000f777) == 32'h00000000) else $error("reserved line enabled");
  scr_keep_a: assert property (
    csr_req.access && csr_req.write && !csr_req.user_mode && csr_req.addr == 12'h340
    ##1 !csr_req.access ##1 csr_req.access && !csr_req.write && csr_req.addr == 12'h340
    |=> csr_rsp.rdata == $past(csr_req.wdata, 3)) else $error("scratch lost");
  zero_reg_a: assert property (
    csr_req.access && csr_req.addr inside {12'h30a, 12'h310, 12'h31a, [12'h323:12'h33f]}
    |=> csr_rsp.hit && csr_rsp.rdata == 32'h00000000) else $error("zero reg nonzero");
  tvec_low_a: assert property (
    csr_req.access && csr_req.addr == 12'h305 |=> csr_rsp.rdata[6:2] == 5'h00)
    else $error("vector low bits set");
  nmi_pc_a: assert property (
    trap_req.take && trap_req.nmi |=> handler_pc[6:0] == 7'h3c) else $error("nmi entry wrong");
  illegal_m_a: assert property (
    csr_req.access && !csr_req.user_mode |=> !csr_rsp.illegal) else $error("machine illegal");
  inhib_rst_a: assert property (
    $fell(rst) |-> cycle_inhibit && retired_inhibit) else $error("inhibit reset wrong");
  handler_ack_a: assert property (
    1'b1 |=> handler_valid == $past(trap_req.take)) else $error("handler pulse wrong");
  cover property (trap_req.take && trap_req.nmi);
  cover property (csr_req.access && csr_req.user_mode);
  cover property (csr_rsp.illegal);
endmodule : mtcsr_bank_chk

bind mtcsr_bank mtcsr_bank_chk chk_u (.*);

// ==== mtcsr_consts.svh ====
`ifndef MTCSR_CONSTS_SVH
`define MTCSR_CONSTS_SVH

`define MTCSR_ADDR_W 12
`define MTCSR_A_IE 12'h304
`define MTCSR_A_TVEC 12'h305
`define MTCSR_A_CNTEN 12'h306
`define MTCSR_A_TVT 12'h307
`define MTCSR_A_ENVLO 12'h30a
`define MTCSR_A_STATH 12'h310
`define MTCSR_A_ENVHI 12'h31a
`define MTCSR_A_INHIB 12'h320
`define MTCSR_A_EVT_LO 12'h323
`define MTCSR_A_EVT_HI 12'h33f
`define MTCSR_A_SCR 12'h340
`define MTCSR_A_UCYC 12'hc00
`define MTCSR_A_URET 12'hc02
`define MTCSR_A_UCYCH 12'hc80
`define MTCSR_A_URETH 12'hc82

`define MTCSR_IE_MASK 32'hffff0888
`define MTCSR_TVEC_BASE_MASK 32'hffffff80
`define MTCSR_TVT_MIN_LSB 6
`define MTCSR_TVT_ID_LSB 2
`define MTCSR_CNT_MASK 32'h00000005
`define MTCSR_INHIB_RST 32'h00000005
`define MTCSR_ZERO 32'h00000000
`define MTCSR_CY_BIT 0
`define MTCSR_IR_BIT 2
`define MTCSR_BASE_LSB 7
`define MTCSR_MODE_W 2
`define MTCSR_MODE_DIRECT 2'h0
`define MTCSR_MODE_VECT 2'h1
`define MTCSR_MODE_CLIC 2'h3
`define MTCSR_NMI_IDX 5'hf
`define MTCSR_IDX_W 5
`define MTCSR_ALIGN_PAD 2'h0

`endif

// ==== mtcsr_pkg.sv ====
package mtcsr_pkg;
  typedef struct packed {
    logic access;
    logic write;
    logic user_mode;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mtcsr_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic illegal;
    logic [31:0] rdata;
  } mtcsr_rsp_t;

  typedef struct packed {
    logic take;
    logic nmi;
    logic irq;
    logic [4:0] cause;
  } mtcsr_trap_t;

  typedef enum logic [1:0] {
    MTCSR_BOOT_WAIT,
    MTCSR_RUN
  } mtcsr_state_t;
endpackage : mtcsr_pkg

// ==== testbench.sv ====
module testbench
  import mtcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} mtcsr_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] irq_lines = 32'hffffffff;
  mtcsr_req_t csr_req = '0;
  mtcsr_trap_t trap_req = '0;
  mtcsr_rsp_t csr_rsp;
  mtcsr_rsp_t rsp;
  mtcsr_rsp_t csr_rsp_v;
  mtcsr_rsp_t rsp_v;
  logic [31:0] irq_enabled_v;
  logic [31:0] irq_enabled;
  logic [31:0] handler_pc;
  logic handler_valid;
  logic cycle_inhibit;
  logic retired_inhibit;
  int miscompares = 0;
  int cmp_count = 0;
  mtcsr_row_t rows [12] = '{
    '{12'h340, 32'ha5a55a5a, 32'ha5a55a5a}, '{12'h304, 32'hffffffff, 32'hffff0888},
    '{12'h306, 32'hffffffff, 32'h00000005}, '{12'h320, 32'hffffffff, 32'h00000005},
    '{12'h305, 32'h12345678, 32'h12345600}, '{12'h307, 32'hffffffff, 32'h00000000},
    '{12'h30a, 32'hffffffff, 32'h00000000}, '{12'h310, 32'hffffffff, 32'h00000000},
    '{12'h31a, 32'hffffffff, 32'h00000000}, '{12'h323, 32'hffffffff, 32'h00000000},
    '{12'h33f, 32'hffffffff, 32'h00000000}, '{12'h123, 32'hffffffff, 32'h00000000}};

  mtcsr_bank dut_u (.ref_clk(ref_clk), .rst(rst), .boot_addr(32'h800001ff),
    .csr_req(csr_req), .csr_rsp(csr_rsp), .irq_lines(irq_lines), .irq_enabled(irq_enabled),
    .trap_req(trap_req), .handler_valid(handler_valid), .handler_pc(handler_pc),
    .cycle_inhibit(cycle_inhibit), .retired_inhibit(retired_inhibit));

  // Second bank with the vectored controller option
  mtcsr_bank #(.VECT_CTRL_EN(1'b1), .ID_WIDTH(8)) dut_v_u (.ref_clk(ref_clk), .rst(rst),
    .boot_addr(32'h800001ff), .csr_req(csr_req), .csr_rsp(csr_rsp_v), .irq_lines(irq_lines),
    .irq_enabled(irq_enabled_v), .trap_req(trap_req), .handler_valid(), .handler_pc(),
    .cycle_inhibit(), .retired_inhibit());

  always #20 ref_clk = ~ref_clk;

  task automatic results();
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic acc(input logic w, input logic u, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    csr_req <= '{1'b1, w, u, a, d};
    @(posedge ref_clk);
    csr_req.access <= 1'b0;
    @(negedge ref_clk);
    rsp = csr_rsp;
    rsp_v = csr_rsp_v;
  endtask : acc

  task automatic trp(input logic n, input logic q, input logic [4:0] c, input logic [31:0] e);
    @(posedge ref_clk);
    trap_req <= '{1'b1, n, q, c};
    @(posedge ref_clk);
    trap_req.take <= 1'b0;
    @(negedge ref_clk);
    chk("handler_pc", handler_pc, e);
    chk("handler_valid", 32'(handler_valid), 32'h00000001);
  endtask : trp

  initial begin
    repeat (1000) @(posedge ref_clk);
    miscompares++;
    results();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    acc(1'b0, 1'b0, 12'h305, 32'h00000000);
    chk("tvec_reset", rsp.rdata, 32'h80000181);
    chk("tvec_reset_v", rsp_v.rdata, 32'h80000183);
    chk("rsp_valid", 32'(rsp.valid), 32'h00000001);
    chk("inhibit_reset", 32'({cycle_inhibit, retired_inhibit}), 32'h00000003);
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i].a, rows[i].d);
      acc(1'b0, 1'b0, rows[i].a, 32'h00000000);
      chk("row_rdata", rsp.rdata, rows[i].e);
    end
    chk("irq_enabled", irq_enabled, 32'hffff0888);
    chk("irq_enabled_v", irq_enabled_v, 32'h00000000);
    acc(1'b0, 1'b0, 12'h304, 32'h00000000);
    chk("ie_v", rsp_v.rdata, 32'h00000000);
    acc(1'b0, 1'b0, 12'h307, 32'h00000000);
    chk("tvt_hit", 32'(rsp.hit), 32'h00000000);
    chk("tvt_v", rsp_v.rdata, 32'hfffffc00);
    acc(1'b0, 1'b0, 12'h123, 32'h00000000);
    chk("miss_hit", 32'(rsp.hit), 32'h00000000);
    acc(1'b1, 1'b0, 12'h320, 32'h00000000);
    chk("inhibit", 32'({cycle_inhibit, retired_inhibit}), 32'h00000000);
    acc(1'b1, 1'b0, 12'h305, 32'hffffffff);
    acc(1'b0, 1'b0, 12'h305, 32'h00000000);
    chk("tvec_mode", rsp.rdata, 32'hffffff80);
    acc(1'b1, 1'b0, 12'h305, 32'h00000101);
    acc(1'b0, 1'b0, 12'h305, 32'h00000000);
    chk("tvec_vect", rsp.rdata, 32'h00000101);
    chk("tvec_mode_v", rsp_v.rdata, 32'h00000103);
    trp(1'b0, 1'b1, 5'h05, 32'h00000114);
    trp(1'b1, 1'b0, 5'h00, 32'h0000013c);
    trp(1'b0, 1'b0, 5'h02, 32'h00000100);
    acc(1'b1, 1'b1, 12'h340, 32'h00000000);
    acc(1'b0, 1'b1, 12'h340, 32'h00000000);
    chk("user_write", rsp.rdata, 32'ha5a55a5a);
    acc(1'b0, 1'b1, 12'hc00, 32'h00000000);
    chk("cycle_ok", 32'(rsp.illegal), 32'h00000000);
    acc(1'b1, 1'b0, 12'h306, 32'h00000001);
    acc(1'b0, 1'b1, 12'hc02, 32'h00000000);
    chk("retired_bad", 32'(rsp.illegal), 32'h00000001);
    results();
  end
endmodule : testbench
